// file: inc/cmd_link_defines.svh
/*
  Constants for the drive-side serial command link fault handler: word layout
  and handshake timeout figures. Assumes a 10 MHz core clock.
*/
// Functional notes
// R1: either side missing a handshake edge for 10 ms is an interface fault.
// R2: an interface fault may cut a word short; the partial word is dropped.
// R3: parity is checked only once all 17 bits of a word have moved.
// R4: even bit errors may decode as invalid commands; reported as a command fault.
// R5: fault with attention low: raise attention first, then command complete.
// R6: command complete only after attention is up and controller dropped its request.
// R7: after command complete the next handshaked bit starts a new command word.
// R8: fault with attention already high: withhold the answer to the next request.
// R9: controller abandons the transfer on an interface fault and awaits complete.
// R10: controller drops request on attention and waits for command complete.
// R11: after such a fault every request is ignored until command complete.
// R12: the drive times the controller from the leading edge of its acknowledge.
// R13: next request must come within 10 ms of acknowledge trailing edge.
// R14: controller requests the first response bit after the command parity bit.
// R15: controller watches attention and command complete to resynchronize.
// R16: muted fault: no request for 10 ms after acknowledge fall gives complete.
// R17: a response-bit request in that window is not answered.
// R18: further requests within 10 ms of the previous one are also ignored.
// R19: controller sends no response request for a command without response.
// R20: complete drops on the first command bit, rises when execution ends.
// R21: controller requests status, resets attention, then resends the command.
// R22: 16 data bits then one parity bit, odd count of ones over 17.
// R23: timeouts come from a counter on the core clock, restarted at each edge.
`ifndef CMD_LINK_DEFINES_SVH
`define CMD_LINK_DEFINES_SVH

`define CL_DATA_BITS    16
`define CL_WORD_BITS    17
`define CL_CNT_BITS     5
`define CL_TMO_MS       10
`define CL_CLK_KHZ      10000
`define CL_TMO_CYCLES   (`CL_TMO_MS * `CL_CLK_KHZ)
`define CL_TMR_BITS     17

`endif

// file: inc/cmd_link_pkg.sv
/*
  Types for the drive-side command link fault handler.
  Assumes nothing beyond the defines header for widths.
*/
package cmd_link_pkg;

  // link sequencing states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RX_ACK,
    ST_RX_GAP,
    ST_EXEC,
    ST_TX_GAP,
    ST_TX_ACK,
    ST_FAULT_ATTN,
    ST_FAULT_MUTE
  } link_state_e;

  // kind of communication fault last seen
  typedef enum logic [1:0] {
    FK_NONE,
    FK_IFACE,
    FK_PARITY,
    FK_COMMAND
  } fault_kind_e;

endpackage

// file: logic/hs_timeout_timer.sv
/*
  Handshake timeout counter. Restarts on a pulse and flags expiry once the
  limit is reached. Assumes a single core clock and asynchronous low reset.
*/
`timescale 1ns/1ps
`include "cmd_link_defines.svh"

module hs_timeout_timer #(
  parameter int unsigned LIMIT = `CL_TMO_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // control
  input  wire logic restart,
  output logic      expired
);

  logic [`CL_TMR_BITS-1:0] cnt_reg;
  logic [`CL_TMR_BITS-1:0] cnt_next;
  localparam logic [`CL_TMR_BITS-1:0] LAST = `CL_TMR_BITS'(LIMIT - 1);

  // count up from each restart, saturate at the limit
  always_comb begin
    if (restart) begin
      cnt_next = '0;
    end else if (cnt_reg != LAST) begin
      cnt_next = cnt_reg + `CL_TMR_BITS'(1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // counter register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == LAST); // [R23]

endmodule // hs_timeout_timer

// file: logic/cmd_link_fault_resync.sv
/*
  Drive-side serial command/status link with fault detection, termination and
  resynchronization. Receives 17-bit command words, returns 17-bit response
  words, and handles timeouts, parity faults and rejected commands.
  Assumes link inputs are synchronous to core_clk and that the command decoder
  and status logic sit on the user side.
  The timeout limit is a parameter so that a bench can shorten it; at the
  10 MHz core clock the default gives the 10 ms handshake limit.
  A muted fault rearms its quiet window on every request rise, so a controller
  that keeps pulsing requests will not see command complete until it stops.
  Only one word is held at a time; a cut word is dropped, never delivered.
*/
`timescale 1ns/1ps
`include "cmd_link_defines.svh"

module cmd_link_fault_resync #(
  parameter int unsigned TIMEOUT_CYCLES = `CL_TMO_CYCLES
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // serial link to controller
  input  wire logic                     xfer_req,
  input  wire logic                     cmd_data,
  output logic                          xfer_ack,
  output logic                          status_data,
  output logic                          attention,
  output logic                          cmd_complete,
  // command decoder side
  output logic [`CL_DATA_BITS-1:0]      cmd_word,
  output logic                          cmd_valid,
  input  wire logic                     cmd_reject,
  input  wire logic                     resp_load,
  input  wire logic [`CL_DATA_BITS-1:0] resp_word,
  input  wire logic                     exec_done,
  // attention control
  input  wire logic                     attn_other,
  input  wire logic                     attn_clear,
  // fault report
  output logic                          comm_fault,
  output cmd_link_pkg::fault_kind_e     fault_kind
);

  localparam logic [`CL_CNT_BITS-1:0] WORD_LEN = `CL_CNT_BITS'(`CL_WORD_BITS);

  // sequencing state and fault record
  cmd_link_pkg::link_state_e  state_reg;
  cmd_link_pkg::link_state_e  state_next;
  cmd_link_pkg::fault_kind_e  kind_reg;
  cmd_link_pkg::fault_kind_e  kind_next;
  // word shifting in and out
  logic [`CL_CNT_BITS-1:0]    bit_cnt_reg;
  logic [`CL_CNT_BITS-1:0]    bit_cnt_next;
  logic [`CL_WORD_BITS-1:0]   shift_reg;
  logic [`CL_WORD_BITS-1:0]   shift_next;
  logic [`CL_WORD_BITS-1:0]   tx_reg;
  logic [`CL_WORD_BITS-1:0]   tx_next;
  logic [`CL_DATA_BITS-1:0]   word_reg;
  logic [`CL_DATA_BITS-1:0]   word_next;
  // registered link and user outputs
  logic                       ack_reg;
  logic                       ack_next;
  logic                       sdata_reg;
  logic                       sdata_next;
  logic                       comm_attn_reg;
  logic                       comm_attn_next;
  logic                       attn_reg;
  logic                       attn_next;
  logic                       cc_reg;
  logic                       cc_next;
  // request edge detect and one-cycle strobes
  logic                       req_d_reg;
  logic                       valid_reg;
  logic                       valid_next;
  logic                       fault_reg;
  logic                       fault_next;
  // timer control and fault entry
  logic                       tmr_restart;
  logic                       tmr_expired;
  logic                       do_fault;
  cmd_link_pkg::fault_kind_e  fault_sel;
  logic                       req_rise;

  // timeout source for every handshake wait except the request drop awaited in ST_FAULT_ATTN
  hs_timeout_timer #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .restart  (tmr_restart),
    .expired  (tmr_expired)
  );

  // request rise; the delay flop resets low like an idle pin, so no false edge
  assign req_rise = xfer_req & ~req_d_reg;

  // link sequencing and fault handling
  always_comb begin
    state_next     = state_reg;
    kind_next      = kind_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    tx_next        = tx_reg;
    word_next      = word_reg;
    ack_next       = ack_reg;
    sdata_next     = sdata_reg;
    comm_attn_next = comm_attn_reg;
    cc_next        = cc_reg;
    valid_next     = 1'b0;
    fault_next     = 1'b0;
    tmr_restart    = 1'b0;
    do_fault       = 1'b0;
    fault_sel      = cmd_link_pkg::FK_NONE;
    unique case (state_reg)
      cmd_link_pkg::ST_IDLE: begin
        // first handshaked bit always opens a new command word
        if (xfer_req) begin
          cc_next      = 1'b0;                                      // [R20] [R7]
          shift_next   = {shift_reg[`CL_WORD_BITS-2:0], cmd_data};
          bit_cnt_next = `CL_CNT_BITS'(1);
          ack_next     = 1'b1;
          tmr_restart  = 1'b1;                                      // [R12]
          state_next   = cmd_link_pkg::ST_RX_ACK;
        end
      end

      cmd_link_pkg::ST_RX_ACK: begin
        // bit acknowledged; wait for the request to drop
        if (!xfer_req) begin
          ack_next    = 1'b0;
          tmr_restart = 1'b1;                                       // [R13]
          if (bit_cnt_reg == WORD_LEN) begin
            // parity judged only on the whole word
            if (^shift_reg) begin                                   // [R3] [R22]
              word_next  = shift_reg[`CL_WORD_BITS-1:1];
              valid_next = 1'b1;
              state_next = cmd_link_pkg::ST_EXEC;
            end else begin
              do_fault  = 1'b1;
              fault_sel = cmd_link_pkg::FK_PARITY;
            end
          end else begin
            state_next = cmd_link_pkg::ST_RX_GAP;
          end
        end else if (tmr_expired) begin
          do_fault  = 1'b1;                                         // [R1] [R12]
          fault_sel = cmd_link_pkg::FK_IFACE;
        end
      end

      cmd_link_pkg::ST_RX_GAP: begin
        // between bits; the next request shifts in the next bit
        if (xfer_req) begin
          shift_next   = {shift_reg[`CL_WORD_BITS-2:0], cmd_data};
          bit_cnt_next = bit_cnt_reg + `CL_CNT_BITS'(1);
          ack_next     = 1'b1;
          tmr_restart  = 1'b1;
          state_next   = cmd_link_pkg::ST_RX_ACK;
        end else if (tmr_expired) begin
          do_fault  = 1'b1;                                         // [R13] [R2]
          fault_sel = cmd_link_pkg::FK_IFACE;
        end
      end

      cmd_link_pkg::ST_EXEC: begin
        // decoder verdict, response or plain completion
        if (cmd_reject) begin
          do_fault  = 1'b1;                                         // [R4]
          fault_sel = cmd_link_pkg::FK_COMMAND;
        end else if (resp_load) begin
          tx_next      = {resp_word, ~^resp_word};                  // [R22]
          bit_cnt_next = '0;
          tmr_restart  = 1'b1;
          state_next   = cmd_link_pkg::ST_TX_GAP;
        end else if (exec_done) begin
          cc_next    = 1'b1;                                        // [R20]
          state_next = cmd_link_pkg::ST_IDLE;
        end
      end

      cmd_link_pkg::ST_TX_GAP: begin
        // next response bit waits for its request
        if (xfer_req) begin
          sdata_next   = tx_reg[`CL_WORD_BITS-1];
          tx_next      = {tx_reg[`CL_WORD_BITS-2:0], 1'b0};
          bit_cnt_next = bit_cnt_reg + `CL_CNT_BITS'(1);
          ack_next     = 1'b1;
          tmr_restart  = 1'b1;                                      // [R12]
          state_next   = cmd_link_pkg::ST_TX_ACK;
        end else if (tmr_expired) begin
          do_fault  = 1'b1;                                         // [R13] [R2]
          fault_sel = cmd_link_pkg::FK_IFACE;
        end
      end

      cmd_link_pkg::ST_TX_ACK: begin
        // response bit stands on the line until the request drops
        if (!xfer_req) begin
          ack_next    = 1'b0;
          tmr_restart = 1'b1;
          if (bit_cnt_reg == WORD_LEN) begin
            cc_next    = 1'b1;                                      // [R20]
            state_next = cmd_link_pkg::ST_IDLE;
          end else begin
            state_next = cmd_link_pkg::ST_TX_GAP;
          end
        end else if (tmr_expired) begin
          do_fault  = 1'b1;                                         // [R1]
          fault_sel = cmd_link_pkg::FK_IFACE;
        end
      end

      cmd_link_pkg::ST_FAULT_ATTN: begin
        // attention is up; complete once the request has gone away
        if (!xfer_req && attn_reg) begin
          cc_next      = 1'b1;                                      // [R5] [R6]
          bit_cnt_next = '0;                                        // [R7]
          state_next   = cmd_link_pkg::ST_IDLE;
        end
      end

      cmd_link_pkg::ST_FAULT_MUTE: begin
        // requests go unanswered; each one rearms the quiet window
        if (req_rise) begin
          tmr_restart = 1'b1;                                       // [R8] [R11] [R17] [R18]
        end else if (tmr_expired && !xfer_req) begin
          cc_next      = 1'b1;                                      // [R16]
          bit_cnt_next = '0;                                        // [R7]
          state_next   = cmd_link_pkg::ST_IDLE;
        end
      end
      // unused state codes fall back to idle
      default: begin
        state_next = cmd_link_pkg::ST_IDLE;
      end
    endcase
    // common fault entry; the partial word is dropped
    if (do_fault) begin
      fault_next   = 1'b1;
      kind_next    = fault_sel;
      ack_next     = 1'b0;
      bit_cnt_next = '0;                                            // [R2]
      tmr_restart  = 1'b1;
      if (attn_reg) begin
        // attention already up: go quiet and let the controller time out
        state_next = cmd_link_pkg::ST_FAULT_MUTE;                   // [R8]
      end else begin
        // attention low: raising it tells the controller to stop
        comm_attn_next = 1'b1;                                      // [R5]
        state_next     = cmd_link_pkg::ST_FAULT_ATTN;
      end
    end else if (attn_clear) begin
      comm_attn_next = 1'b0;
    end
    // attention is the comm fault flag or any other drive fault
    attn_next = comm_attn_next | attn_other;
  end

  // state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= cmd_link_pkg::ST_IDLE;
      kind_reg      <= cmd_link_pkg::FK_NONE;
      bit_cnt_reg   <= '0;
      shift_reg     <= '0;
      tx_reg        <= '0;
      word_reg      <= '0;
      ack_reg       <= 1'b0;
      sdata_reg     <= 1'b0;
      comm_attn_reg <= 1'b0;
      attn_reg      <= 1'b0;
      cc_reg        <= 1'b1;
      req_d_reg     <= 1'b0;
      valid_reg     <= 1'b0;
      fault_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      kind_reg      <= kind_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      tx_reg        <= tx_next;
      word_reg      <= word_next;
      ack_reg       <= ack_next;
      sdata_reg     <= sdata_next;
      comm_attn_reg <= comm_attn_next;
      attn_reg      <= attn_next;
      cc_reg        <= cc_next;
      req_d_reg     <= xfer_req;
      valid_reg     <= valid_next;
      fault_reg     <= fault_next;
    end
  end

  // outputs straight from flops
  assign xfer_ack     = ack_reg;
  assign status_data  = sdata_reg;
  assign attention    = attn_reg;
  assign cmd_complete = cc_reg;
  assign cmd_word     = word_reg;
  assign cmd_valid    = valid_reg;
  assign comm_fault   = fault_reg;
  assign fault_kind   = kind_reg;

endmodule // cmd_link_fault_resync

// file: test/cmd_link_checker.sv
/* port assertions for the drive link fault handler.
   assumes one core clock; bound to the link block. */
`timescale 1ns/1ps
module cmd_link_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rstn,
  // link and user side
  input wire logic                      xfer_req,
  input wire logic                      xfer_ack,
  input wire logic                      attention,
  input wire logic                      cmd_complete,
  input wire logic                      cmd_valid,
  input wire logic                      cmd_reject,
  input wire logic                      comm_fault,
  input wire cmd_link_pkg::fault_kind_e fault_kind
);
  logic [31:0] hold_reg;
  logic [31:0] hold_next;
  // cycles with acknowledge and request both up
  always_comb hold_next = (xfer_ack && xfer_req) ? hold_reg + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) hold_reg <= 32'h0000_0000;
    else hold_reg <= hold_next;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // fault steps: attention first, complete still low
  sequence raise_s;
    !cmd_complete ##[0:1] (attention && !cmd_complete);
  endsequence
  ack_cause_a: assert property ($rose(xfer_ack) |-> $past(xfer_req)) else $error("ack without request");
  ack_release_a: assert property (xfer_ack && !xfer_req |-> ##[1:2] !xfer_ack) else $error("ack stuck");
  fault_attn_a: assert property (comm_fault && !$past(attention) |-> raise_s) else $error("no attention");
  cc_quiet_a: assert property ($rose(cmd_complete) |-> !xfer_req) else $error("complete too early");
  mute_quiet_a: assert property (comm_fault && $past(attention) |=> (!xfer_ack)[*8]) else $error("mute ack");
  cc_first_bit_a: assert property ($rose(xfer_ack) |-> !cmd_complete) else $error("complete high");
  valid_pulse_a: assert property (cmd_valid |-> !comm_fault ##1 !cmd_valid) else $error("bad valid");
  reject_kind_a: assert property (cmd_reject |-> ##[1:3] (fault_kind == cmd_link_pkg::FK_COMMAND))
    else $error("no command fault");
  hold_bound_a: assert property (hold_reg <= TIMEOUT_CYCLES + 2) else $error("ack timeout missed");
endmodule // cmd_link_checker

bind cmd_link_fault_resync cmd_link_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
  .core_clk(core_clk), .rstn(rstn), .xfer_req(xfer_req), .xfer_ack(xfer_ack),
  .attention(attention), .cmd_complete(cmd_complete), .cmd_valid(cmd_valid),
  .cmd_reject(cmd_reject), .comm_fault(comm_fault), .fault_kind(fault_kind));

// file: test/ctrl_model.sv
/* controller model: drives the interlocked request handshake.
   assumes inputs change at the falling edge of core_clk. */
`timescale 1ns/1ps
module ctrl_model (
  // clock
  input  wire logic core_clk,
  // link
  input  wire logic xfer_ack,
  input  wire logic status_data,
  output logic      xfer_req,
  output logic      cmd_data
);
  // idle link at time zero
  initial begin
    xfer_req = 1'b0;
    cmd_data = 1'b0;
  end
  // one bit; ok low when unanswered, hold keeps the request after ack
  task automatic xfer(input logic b, input int hold, output logic rb, output logic ok);
    int n;
    @(negedge core_clk);
    xfer_req = 1'b1;
    cmd_data = b;
    for (n = 0; n < 10 && xfer_ack !== 1'b1; n++) @(negedge core_clk);
    ok = (xfer_ack === 1'b1);
    rb = status_data;
    repeat (hold) @(negedge core_clk);
    xfer_req = 1'b0;
    cmd_data = ~b;
    for (n = 0; n < 10 && xfer_ack !== 1'b0; n++) @(negedge core_clk);
  endtask
endmodule // ctrl_model

// file: test/command_link_fault_resync_tb_top.sv
/* bench for the drive link fault handler: controller model, word scoreboard.
   assumes model and checker compiled first. */
`timescale 1ns/1ps
`include "cmd_link_defines.svh"
module command_link_fault_resync_tb_top;
  localparam int unsigned TMO = 20;
  // clock, reset, link
  logic                      core_clk = 1'b0;
  logic                      rstn = 1'b0;
  logic                      xfer_req;
  logic                      cmd_data;
  logic                      xfer_ack;
  logic                      status_data;
  logic                      attention;
  logic                      cmd_complete;
  // user side
  logic [`CL_DATA_BITS-1:0]  cmd_word;
  logic [`CL_DATA_BITS-1:0]  resp_word = 16'h0000;
  logic                      cmd_valid;
  logic                      cmd_reject = 1'b0;
  logic                      resp_load = 1'b0;
  logic                      exec_done = 1'b0;
  logic                      attn_other = 1'b0;
  logic                      attn_clear = 1'b0;
  logic                      comm_fault;
  cmd_link_pkg::fault_kind_e fault_kind;
  // scoreboard
  int unsigned               mismatches = 0;
  int unsigned               checked = 0;
  int unsigned               seed = 38;
  int                        nfault = 0;
  logic [15:0]               exp_q[$];

  always #50 core_clk = ~core_clk;

  cmd_link_fault_resync #(.TIMEOUT_CYCLES(TMO)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .xfer_req(xfer_req), .cmd_data(cmd_data),
    .xfer_ack(xfer_ack), .status_data(status_data), .attention(attention),
    .cmd_complete(cmd_complete), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .cmd_reject(cmd_reject), .resp_load(resp_load), .resp_word(resp_word),
    .exec_done(exec_done), .attn_other(attn_other), .attn_clear(attn_clear),
    .comm_fault(comm_fault), .fault_kind(fault_kind));

  ctrl_model i_ctrl (.core_clk(core_clk), .xfer_ack(xfer_ack), .status_data(status_data),
    .xfer_req(xfer_req), .cmd_data(cmd_data));

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // top n bits of a word, first bit first
  task automatic send(input logic [16:0] w, input int n, output logic ok);
    logic rb;
    ok = 1'b1;
    for (int i = 16; i > 16 - n && ok; i--) i_ctrl.xfer(w[i], 0, rb, ok);
  endtask

  task automatic pulse(ref logic s);
    repeat (2) @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic wait_cc();
    int n;
    for (n = 0; n < 200 && cmd_complete !== 1'b1; n++) @(negedge core_clk);
    if (n == 200) begin
      mismatches++;
      test_done();
    end
  endtask

  // every delivered word against the expected queue; fault count
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1 && exp_q.size() != 0) chk(cmd_word, exp_q.pop_front());
    else if (cmd_valid === 1'b1) chk(17'h1_ffff, 17'h0_0000);
    if (comm_fault === 1'b1) nfault++;
  end

  // good words, then faults, then a resync word
  initial begin
    logic [15:0] d;
    logic [16:0] rw;
    logic        ok;
    logic        rb;
    int          nf;
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    chk(cmd_complete, 1'b1);
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      exp_q.push_back(d); // the rejected word still has good parity
      send({d, ~^d}, 17, ok);
      chk(cmd_complete, 1'b0);
      if (k == 0) pulse(exec_done);
      if (k == 1) begin
        resp_word = rnd();
        pulse(resp_load);
        for (int i = 16; i >= 0; i--) begin
          i_ctrl.xfer(1'b0, 0, rb, ok);
          rw[i] = rb;
        end
        chk(rw, {resp_word, ~^resp_word});
      end
      if (k == 2) pulse(cmd_reject);
      wait_cc();
      chk(attention, k == 2);
    end
    chk(fault_kind, cmd_link_pkg::FK_COMMAND);
    pulse(attn_clear);
    for (int f = 0; f < 5; f++) begin
      d = rnd();
      attn_other = (f > 2);
      nf = nfault;
      if (f == 0 || f > 2) send({d, ^d}, 17, ok);
      else send({d, ~^d}, (f == 1) ? 5 : 3, ok);
      if (f == 2) i_ctrl.xfer(1'b0, 30, rb, ok);
      if (f == 3) repeat (2) begin
        i_ctrl.xfer(1'b0, 0, rb, ok);
        chk(ok, 1'b0);
      end
      wait_cc();
      chk(fault_kind, (f == 1 || f == 2) ? cmd_link_pkg::FK_IFACE : cmd_link_pkg::FK_PARITY);
      chk(attention, 1'b1);
      chk(nfault - nf, 1);
      pulse(attn_clear);
    end
    attn_other = 1'b0;
    d = rnd();
    exp_q.push_back(d);
    send({d, ~^d}, 17, ok);
    pulse(exec_done);
    wait_cc();
    chk(attention, 1'b0);
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule // command_link_fault_resync_tb_top
